// File: core/rimsu_pkg.sv
// constants, register map and field layout of the interrupt mask/source unit
package rimsu_pkg;

   localparam int unsigned DATA_W = 32;
   localparam int unsigned ADDR_W = 12;
   localparam int unsigned FLAG_W = 8;
   localparam int unsigned IDX_W  = 10;

   typedef logic [FLAG_W-1:0] rimsu_flags_t;

   // register indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_LINK_ENABLE = 10'h100;
   localparam logic [IDX_W-1:0] IDX_HK_ENABLE   = 10'h101;
   localparam logic [IDX_W-1:0] IDX_LINK_FLAGS  = 10'h336;
   localparam logic [IDX_W-1:0] IDX_HK_FLAGS    = 10'h337;
   localparam logic [IDX_W-1:0] IDX_STATUS      = 10'h338;

   // link-level event bit positions
   localparam int unsigned LNK_WAKEUP_COUNT  = 7;
   localparam int unsigned LNK_SMART_WAKE    = 6;
   localparam int unsigned LNK_CIPHER_DONE   = 5;
   localparam int unsigned LNK_TX_DONE       = 4;
   localparam int unsigned LNK_ADDR_MATCH    = 3;
   localparam int unsigned LNK_CRC_OK        = 2;
   localparam int unsigned LNK_SYNC_FOUND    = 1;
   localparam int unsigned LNK_PREAMBLE_SEEN = 0;

   // housekeeping event bit positions
   localparam int unsigned HK_BATTERY_ALARM  = 7;
   localparam int unsigned HK_CMD_READY      = 6;
   localparam int unsigned HK_WAKE_TIMER_EXP = 4;
   localparam int unsigned HK_PORT_READY     = 1;
   localparam int unsigned HK_CMD_FINISHED   = 0;

   // implemented housekeeping bits; 5, 3 and 2 are reserved
   localparam rimsu_flags_t HK_IMPL_MASK   = 8'hd3;
   // link bits that exist only in packet mode
   localparam rimsu_flags_t LNK_PKT_ONLY   = 8'h1c;
   // link bit that exists only with the cipher module loaded
   localparam rimsu_flags_t LNK_CIPHER_BIT = 8'h20;

   localparam rimsu_flags_t FLAGS_RESET  = 8'h00;
   localparam rimsu_flags_t ENABLE_RESET = 8'h00;

   localparam int unsigned STATUS_IRQ_BIT = 0;

   function automatic logic [ADDR_W-1:0] reg_addr(input logic [IDX_W-1:0] idx);
      reg_addr = {idx, 2'b00};
   endfunction : reg_addr

endpackage : rimsu_pkg

// File: core/rimsu_flag_bank.sv
// bank of sticky event flags, set by allowed events, cleared by writing ones
`timescale 1ns/1ps
module rimsu_flag_bank (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire rimsu_pkg::rimsu_flags_t ev,
   input  wire rimsu_pkg::rimsu_flags_t allow,
   input  wire rimsu_pkg::rimsu_flags_t clr,
   output rimsu_pkg::rimsu_flags_t   flags_q
);

   rimsu_pkg::rimsu_flags_t flags_d;

   // set wins over a clear in the same cycle
   always_comb begin
      flags_d = (flags_q & ~clr) | (ev & allow);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags_q <= rimsu_pkg::FLAGS_RESET;
      end else begin
         flags_q <= flags_d;
      end
   end

endmodule : rimsu_flag_bank

// File: core/rimsu_top.sv
// interrupt mask/source unit with apb register access and interrupt pin
//
// Contract
// RULE1 - event raises interrupt only when enabled
// RULE2 - enabled interrupt drives pin and status bit
// RULE3 - host polls pin or status bit
// RULE4 - interrupt never stalls ongoing device activity
// RULE5 - link enable 0x100, housekeeping enable 0x101
// RULE6 - source flags at 0x336 and 0x337
// RULE7 - writing ones clears flags, any combination
// RULE8 - host clears flag after servicing
// RULE9 - pin low only when all flags clear; code drops pin once no enabled flag is set
// RULE10 - battery alarm cleared by 0x80 or 0xff
// RULE11 - link bit 7: wake-up count reached
// RULE12 - link bit 6: smart wake level exceeded
// RULE13 - link bit 5: cipher done, module loaded
// RULE14 - link bit 4: transmit finished
// RULE15 - link bit 3: address match
// RULE16 - link bit 2: crc correct
// RULE17 - link bit 1: sync word found
// RULE18 - link bit 0: preamble found
// RULE19 - housekeeping layout, bits 5,3,2 reserved
// RULE20 - same bit positions; some bits packet-only
// RULE21 - pin is or of flags and enables
`timescale 1ns/1ps
module rimsu_top (
   input  wire logic                        pclk,
   input  wire logic                        presetn,
   input  wire logic                        psel,
   input  wire logic                        penable,
   input  wire logic                        pwrite,
   input  wire logic [rimsu_pkg::ADDR_W-1:0] paddr,
   input  wire logic [rimsu_pkg::DATA_W-1:0] pwdata,
   input  wire logic [3:0]                  pstrb,
   output logic [rimsu_pkg::DATA_W-1:0]     prdata,
   output logic                             pready,
   output logic                             pslverr,
   input  wire rimsu_pkg::rimsu_flags_t     link_ev,
   input  wire rimsu_pkg::rimsu_flags_t     hk_ev,
   input  wire logic                        packet_mode,
   input  wire logic                        cipher_loaded,
   output logic                             irq_out_pin,
   output logic                             status_irq
);

   function automatic logic hit(input logic [rimsu_pkg::ADDR_W-1:0] a,
                                input logic [rimsu_pkg::IDX_W-1:0] idx);
      hit = (a == rimsu_pkg::reg_addr(idx));
   endfunction : hit

   function automatic logic pending(input rimsu_pkg::rimsu_flags_t f,
                                    input rimsu_pkg::rimsu_flags_t m);
      pending = |(f & m);
   endfunction : pending

   rimsu_pkg::rimsu_flags_t        link_mask_q;
   rimsu_pkg::rimsu_flags_t        link_mask_d;
   rimsu_pkg::rimsu_flags_t        hk_mask_q;
   rimsu_pkg::rimsu_flags_t        hk_mask_d;
   rimsu_pkg::rimsu_flags_t        link_flags_q;
   rimsu_pkg::rimsu_flags_t        hk_flags_q;
   rimsu_pkg::rimsu_flags_t        link_avail;
   rimsu_pkg::rimsu_flags_t        link_allow;
   rimsu_pkg::rimsu_flags_t        hk_allow;
   rimsu_pkg::rimsu_flags_t        link_clr;
   rimsu_pkg::rimsu_flags_t        hk_clr;
   logic [rimsu_pkg::DATA_W-1:0]   prdata_q;
   logic [rimsu_pkg::DATA_W-1:0]   prdata_d;
   logic                           pready_q;
   logic                           pready_d;
   logic                           pslverr_q;
   logic                           pslverr_d;
   logic                           irq_q;
   logic                           irq_d;
   logic                           status_q;
   logic                           status_d;
   logic                           setup;
   logic                           wr_en;
   logic                           mapped;
   rimsu_pkg::rimsu_flags_t        wbyte;

   assign setup = psel & ~penable;
   // writes take effect at the access edge where pready is high
   assign wr_en = psel & penable & pwrite & pready_q & ~pslverr_q & pstrb[0];
   assign wbyte = pwdata[rimsu_pkg::FLAG_W-1:0];

   always_comb begin
      mapped = hit(paddr, rimsu_pkg::IDX_LINK_ENABLE) | hit(paddr, rimsu_pkg::IDX_HK_ENABLE) |
               hit(paddr, rimsu_pkg::IDX_LINK_FLAGS) | hit(paddr, rimsu_pkg::IDX_HK_FLAGS) |
               hit(paddr, rimsu_pkg::IDX_STATUS);
   end

   // apb answer: one access cycle, data and error captured in setup
   always_comb begin
      pready_d  = setup;
      pslverr_d = 1'b0;
      prdata_d  = prdata_q;
      if (setup) begin
         pslverr_d = ~mapped;
         prdata_d  = '0;
         if (!pwrite) begin
            // RULE5 enable readback
            if (hit(paddr, rimsu_pkg::IDX_LINK_ENABLE)) begin
               prdata_d[rimsu_pkg::FLAG_W-1:0] = link_mask_q;
            end
            if (hit(paddr, rimsu_pkg::IDX_HK_ENABLE)) begin
               prdata_d[rimsu_pkg::FLAG_W-1:0] = hk_mask_q;
            end
            // RULE6 pending causes readback
            if (hit(paddr, rimsu_pkg::IDX_LINK_FLAGS)) begin
               prdata_d[rimsu_pkg::FLAG_W-1:0] = link_flags_q;
            end
            if (hit(paddr, rimsu_pkg::IDX_HK_FLAGS)) begin
               prdata_d[rimsu_pkg::FLAG_W-1:0] = hk_flags_q;
            end
            if (hit(paddr, rimsu_pkg::IDX_STATUS)) begin
               prdata_d[rimsu_pkg::STATUS_IRQ_BIT] = status_q;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= '0;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // RULE5 enable registers, ones enable
   always_comb begin
      link_mask_d = link_mask_q;
      hk_mask_d   = hk_mask_q;
      if (wr_en && hit(paddr, rimsu_pkg::IDX_LINK_ENABLE)) begin
         link_mask_d = wbyte;
      end
      // RULE19 reserved bits stay zero
      if (wr_en && hit(paddr, rimsu_pkg::IDX_HK_ENABLE)) begin
         hk_mask_d = wbyte & rimsu_pkg::HK_IMPL_MASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         link_mask_q <= rimsu_pkg::ENABLE_RESET;
         hk_mask_q   <= rimsu_pkg::ENABLE_RESET;
      end else begin
         link_mask_q <= link_mask_d;
         hk_mask_q   <= hk_mask_d;
      end
   end

   // RULE20 packet-only and cipher-only sources
   always_comb begin
      link_avail = ~(rimsu_pkg::LNK_PKT_ONLY | rimsu_pkg::LNK_CIPHER_BIT);
      if (packet_mode) begin
         link_avail = link_avail | rimsu_pkg::LNK_PKT_ONLY;
      end
      // RULE13 cipher completion needs module
      if (cipher_loaded) begin
         link_avail = link_avail | rimsu_pkg::LNK_CIPHER_BIT;
      end
   end

   // RULE1 only enabled sources latch
   always_comb begin
      link_allow = link_mask_q & link_avail;
      hk_allow   = hk_mask_q & rimsu_pkg::HK_IMPL_MASK;
   end

   // RULE7 write ones to clear
   always_comb begin
      link_clr = '0;
      hk_clr   = '0;
      if (wr_en && hit(paddr, rimsu_pkg::IDX_LINK_FLAGS)) begin
         link_clr = wbyte;
      end
      if (wr_en && hit(paddr, rimsu_pkg::IDX_HK_FLAGS)) begin
         hk_clr = wbyte;
      end
   end

   // RULE11 RULE12 RULE14 RULE15 RULE16 RULE17 RULE18 link sources by position
   rimsu_flag_bank u_link_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (link_ev),
      .allow   (link_allow),
      .clr     (link_clr),
      .flags_q (link_flags_q)
   );

   // RULE19 housekeeping sources by position
   rimsu_flag_bank u_hk_flags (
      .pclk    (pclk),
      .presetn (presetn),
      .ev      (hk_ev),
      .allow   (hk_allow),
      .clr     (hk_clr),
      .flags_q (hk_flags_q)
   );

   // RULE9 low once flags clear
   // RULE21 pin from flags and enables
   // RULE4 no path back to event sources
   always_comb begin
      irq_d    = pending(link_flags_q, link_mask_q) | pending(hk_flags_q, hk_mask_q);
      status_d = irq_d;
   end

   // RULE2 pin and status bit together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q    <= 1'b0;
         status_q <= 1'b0;
      end else begin
         irq_q    <= irq_d;
         status_q <= status_d;
      end
   end

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign irq_out_pin = irq_q;
   assign status_irq  = status_q;

   // ---- checks ----
   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable;
   endsequence

   sequence s_link_clear_write;
      wr_en && hit(paddr, rimsu_pkg::IDX_LINK_FLAGS);
   endsequence

   property p_setup_then_ready;
      @(posedge pclk) disable iff (!presetn)
         s_setup |=> pready_q ##1 !pready_q;
   endproperty

   // RULE5 readback follows setup
   property p_mask_read;
      @(posedge pclk) disable iff (!presetn)
         (s_setup and (!pwrite && hit(paddr, rimsu_pkg::IDX_LINK_ENABLE)))
            |=> prdata_q[rimsu_pkg::FLAG_W-1:0] == $past(link_mask_q);
   endproperty

   AST_APB_READY: assert property (p_setup_then_ready) // RULE5
      else $error("pready did not follow setup by one cycle");

   AST_MASK_READBACK: assert property (p_mask_read) // RULE5
      else $error("enable register readback mismatch");

   AST_MASKED_NO_SET: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      1'b1 |=> (link_flags_q & ~$past(link_flags_q) & ~$past(link_mask_q)) == 8'h00)
      else $error("disabled link source set its flag");

   AST_PIN_RAISE: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (|(link_ev & link_allow) && !wr_en) ##1 !wr_en |=> irq_out_pin)
      else $error("enabled event did not raise pin within two cycles");

   AST_STATUS_MATCH: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      status_irq == irq_out_pin)
      else $error("status bit and pin disagree");

   AST_PIN_FOLLOWS_FLAGS: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
      1'b1 |=> irq_out_pin == $past(pending(link_flags_q, link_mask_q) | pending(hk_flags_q, hk_mask_q)))
      else $error("pin does not track enabled flags");

   AST_W1C: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      (s_link_clear_write and (link_ev & link_allow) == 8'h00)
         |=> link_flags_q == ($past(link_flags_q) & ~$past(wbyte)))
      else $error("write of ones did not clear link flags");

   AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
      !(wr_en && hit(paddr, rimsu_pkg::IDX_HK_FLAGS)) |=> (hk_flags_q & $past(hk_flags_q)) == $past(hk_flags_q))
      else $error("housekeeping flag dropped without a clear");

   AST_HK_RESERVED: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      (hk_flags_q & ~rimsu_pkg::HK_IMPL_MASK) == 8'h00 && (hk_mask_q & ~rimsu_pkg::HK_IMPL_MASK) == 8'h00)
      else $error("reserved housekeeping bit set");

   AST_PKT_ONLY: assert property (@(posedge pclk) disable iff (!presetn) // RULE20
      !packet_mode |=> (link_flags_q & ~$past(link_flags_q) & rimsu_pkg::LNK_PKT_ONLY) == 8'h00)
      else $error("packet-only flag set outside packet mode");

   AST_CIPHER_GATE: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
      !cipher_loaded |=> (link_flags_q & ~$past(link_flags_q) & rimsu_pkg::LNK_CIPHER_BIT) == 8'h00)
      else $error("cipher flag set without module loaded");

   AST_UNMAPPED_ERR: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      (s_setup and !mapped) |=> pslverr_q && pready_q)
      else $error("unmapped access not flagged as error");

endmodule : rimsu_top

// File: test/rimsu_host_model.sv
// host processor model: apb master that reads, writes and clears interrupt registers
`timescale 1ns/1ps
module rimsu_host_model (
   input  wire logic        pclk,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr
);
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 12'h000;
      pwdata  = 32'h00000000;
      pstrb   = 4'hf;
   end

   task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] sb,
                       output logic [31:0] rd, output logic err);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      pstrb   <= sb;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // only the bench watchdog ends a stuck wait
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      paddr   <= ~a;
      pwdata  <= ~wd;
   endtask : xfer
endmodule : rimsu_host_model

// File: test/tb_top.sv
// self-checking bench of the interrupt mask/source unit
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("BAD %s exp=%h got=%h", nm, exp, got); end end
module tb_top;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic        packet_mode, cipher_loaded, irq_out_pin, status_irq;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, seed;
   logic [3:0]  pstrb;
   logic [7:0]  link_ev, hk_ev;
   int          miscompares, checks;
   localparam logic [11:0] A_LNE = {rimsu_pkg::IDX_LINK_ENABLE, 2'b00};
   localparam logic [11:0] A_HKE = {rimsu_pkg::IDX_HK_ENABLE, 2'b00};
   localparam logic [11:0] A_LNF = {rimsu_pkg::IDX_LINK_FLAGS, 2'b00};
   localparam logic [11:0] A_HKF = {rimsu_pkg::IDX_HK_FLAGS, 2'b00};
   localparam logic [11:0] A_ST  = {rimsu_pkg::IDX_STATUS, 2'b00};

   rimsu_top i_rimsu_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_ev(link_ev), .hk_ev(hk_ev), .packet_mode(packet_mode), .cipher_loaded(cipher_loaded),
      .irq_out_pin(irq_out_pin), .status_irq(status_irq));
   rimsu_host_model i_rimsu_host_model (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   function automatic logic [7:0] exp_flags(input logic hk, input logic [7:0] m, ev, input logic pm, cl);
      logic [7:0] av;
      av = hk ? rimsu_pkg::HK_IMPL_MASK : 8'hff;
      if (!hk && !pm) av = av & ~rimsu_pkg::LNK_PKT_ONLY;
      if (!hk && !cl) av = av & ~rimsu_pkg::LNK_CIPHER_BIT;
      return ev & m & av;
   endfunction : exp_flags

   task automatic conclude();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      i_rimsu_host_model.xfer(1'b1, a, d, 4'hf, rd, err);
      `CHK("wr_err", 1'b0, err)
   endtask : wr

   task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] exp);
      i_rimsu_host_model.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
      `CHK(nm, exp, rd)
   endtask : rd_chk

   // event pulse, then settle to the pin sampling point
   task automatic pulse(input logic hk, input logic [7:0] ev, input logic pm, cl);
      @(posedge pclk);
      packet_mode   <= pm;
      cipher_loaded <= cl;
      if (hk) hk_ev <= ev;
      else link_ev <= ev;
      @(posedge pclk);
      link_ev <= 8'h00;
      hk_ev   <= 8'h00;
      @(posedge pclk);
      #1;
   endtask : pulse

   task automatic trial(input logic hk, input logic [7:0] m, ev, input logic pm, cl);
      logic [7:0]  e, keep;
      logic [11:0] af;
      e = exp_flags(hk, m, ev, pm, cl);
      keep = hk ? rimsu_pkg::HK_IMPL_MASK : 8'hff;
      af = hk ? A_HKF : A_LNF;
      wr(hk ? A_HKE : A_LNE, {24'h0, m});
      i_rimsu_host_model.xfer(1'b0, hk ? A_HKE : A_LNE, 32'h0, 4'h0, rd, err);
      `CHK("enable", {24'h0, m & keep}, rd)
      pulse(hk, ev, pm, cl);
      `CHK("irq_out_pin", |e, irq_out_pin)
      `CHK("status_irq", |e, status_irq)
      rd_chk("status", A_ST, {31'h0, |e});
      rd_chk("flags", af, {24'h0, e});
      wr(af, 32'hff);
      @(posedge pclk);
      #1;
      `CHK("irq_after_clear", 1'b0, irq_out_pin)
      rd_chk("flags_cleared", af, 32'h0);
   endtask : trial

   initial begin
      presetn = 1'b0;
      link_ev = 8'h00;
      hk_ev = 8'h00;
      packet_mode = 1'b0;
      cipher_loaded = 1'b0;
      miscompares = 0;
      checks = 0;
      seed = 32'h8799f6ac;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("lnk_en_rst", A_LNE, 32'h0);
      rd_chk("hk_en_rst", A_HKE, 32'h0);
      rd_chk("lnk_fl_rst", A_LNF, 32'h0);
      rd_chk("hk_fl_rst", A_HKF, 32'h0);
      rd_chk("status_rst", A_ST, 32'h0);
      for (int i = 0; i < 8; i++) trial(1'b0, 8'h01 << i, 8'hff, 1'b1, 1'b1);
      for (int i = 0; i < 8; i++) trial(1'b1, 8'h01 << i, 8'hff, 1'b0, 1'b0);
      trial(1'b0, 8'h00, 8'hff, 1'b1, 1'b1);
      trial(1'b0, 8'hff, 8'hff, 1'b0, 1'b1);
      trial(1'b0, 8'hff, 8'hff, 1'b1, 1'b0);
      repeat (24) begin
         seed = xs(seed);
         trial(seed[24], seed[7:0], seed[15:8], seed[16], seed[17]);
      end
      wr(A_HKE, 32'hff);
      pulse(1'b1, 8'hff, 1'b0, 1'b0);
      rd_chk("hk_all", A_HKF, 32'hd3);
      wr(A_HKF, 32'h80);
      rd_chk("battery_cleared", A_HKF, 32'h53);
      `CHK("pin_others_left", 1'b1, irq_out_pin)
      wr(A_HKF, 32'hff);
      @(posedge pclk);
      #1;
      `CHK("pin_all_clear", 1'b0, irq_out_pin)
      wr(A_LNE, 32'h01);
      pulse(1'b0, 8'h01, 1'b1, 1'b1);
      wr(A_LNE, 32'h00);
      @(posedge pclk);
      #1;
      `CHK("pin_mask_drop", 1'b0, irq_out_pin)
      rd_chk("flag_sticky", A_LNF, 32'h01);
      wr(A_LNF, 32'hff);
      // write with byte lane 0 off must not land
      i_rimsu_host_model.xfer(1'b1, A_LNE, 32'hff, 4'he, rd, err);
      rd_chk("strb_ignored", A_LNE, 32'h0);
      // mid-run reset brings enables back to zero
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd_chk("hk_en_rst2", A_HKE, 32'h0);
      rd_chk("unmapped_data", 12'h000, 32'h0);
      `CHK("unmapped_err", 1'b1, err)
      conclude();
   end

   initial begin
      repeat (8000) @(posedge pclk);
      miscompares++;
      conclude();
   end
endmodule : tb_top
